// File: dv/pll_band_select_setup_sva.sv
// Link protocol and field checks between the two loop ends
`include "pll_consts.svh"
`default_nettype none
module pll_band_select_setup_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        SYS_RST,
  // Link signals
  input wire logic        req,
  input wire logic        we,
  input wire logic [4:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  input wire logic        ref_clk,
  input wire logic        lock
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (SYS_RST);

  property p_ack_next;
    req && !ack |=> ack;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("link ack missing one cycle after request");

  property p_ack_pulse;
    ack |=> !ack && !req;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("link ack or request held past the answer");

  property p_req_hold;
    req && !ack |=> req && $stable(we) && $stable(addr) && $stable(wdata);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("link request changed before its answer");

  property p_rdata_idle;
    !ack |-> rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("link read data outside the answer cycle");

  // Auto request always carries nominal tuning and loop enable
  property p_auto_word;
    req && we && addr == `CFG_ADDR && wdata[`BAND_MSB:`BAND_LSB] == `BAND_AUTO
      |-> wdata[`EN_BIT] && wdata[`BW_MSB:`BW_LSB] == `BW_NOM
      && wdata[`DRV_MSB:`DRV_LSB] == `DRV_NOM && wdata[`BIAS_MSB:`BIAS_LSB] == `BIAS_NOM;
  endproperty
  a_auto_word: assert property (p_auto_word)
    else $error("auto band write without nominal tuning fields");

  property p_locked_band;
    ack && !we && addr == `CFG_ADDR && lock |-> rdata[`BAND_MSB:`BAND_LSB] <= `BAND_MAX;
  endproperty
  a_locked_band: assert property (p_locked_band)
    else $error("locked loop reads back the auto code");

  property p_auto_unlock;
    ack && we && addr == `CFG_ADDR && wdata[`BAND_MSB:`BAND_LSB] == `BAND_AUTO |-> ##2 !lock;
  endproperty
  a_auto_unlock: assert property (p_auto_unlock)
    else $error("lock kept across a new auto search");

  property p_ref_run;
    $rose(ref_clk) |=> ref_clk ##1 !ref_clk ##1 !ref_clk ##1 ref_clk;
  endproperty
  a_ref_run: assert property (p_ref_run)
    else $error("reference clock not free running");
endmodule : pll_band_select_setup_sva
`default_nettype wire

// File: dv/tb_pll_band_select_setup.sv
// Bench joining controller and converter ends over the link
`include "pll_consts.svh"
`default_nettype none
module tb_pll_band_select_setup;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic [1:0]  av_addr  = 2'h0;
  logic        av_rd    = 1'b0;
  logic        av_wr    = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [3:0]  av_be    = 4'hf;
  logic [5:0]  target   = 6'h00;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        loop_on;
  logic [6:0]  vco_mult;
  logic [3:0]  smp_mult;
  logic [31:0] rd_q[$];
  logic [31:0] mk_q[$];
  logic [31:0] lk_q[$];
  logic [31:0] r;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          seed = 32'h0fec;

  always #25 core_clk = ~core_clk;

  pll_cfg_if link_bus (.clk(core_clk));
  pll_band_dev #(.SETTLE(2)) u_pll_band_dev (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
    .LINK(link_bus.dev), .TARGET_BAND(target), .LOOP_ON(loop_on), .VCO_MULT(vco_mult),
    .SAMPLE_MULT(smp_mult));
  pll_band_host #(.LOCK_TIMEOUT(2000), .REF_HALF(2)) u_pll_band_host (.CORE_CLK(core_clk),
    .SYS_RST(sys_rst), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd), .AVS_WRITE(av_wr),
    .AVS_WRITEDATA(av_wdata), .AVS_BYTEENABLE(av_be), .AVS_READDATA(av_rdata),
    .AVS_WAITREQUEST(av_wait), .LINK(link_bus.host));
  pll_band_select_setup_sva u_chk (.clk(link_bus.clk), .SYS_RST(sys_rst), .req(link_bus.req),
    .we(link_bus.we), .addr(link_bus.addr), .wdata(link_bus.wdata), .rdata(link_bus.rdata),
    .ack(link_bus.ack), .ref_clk(link_bus.ref_clk), .lock(link_bus.lock));

  task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : compare

  task automatic test_done;
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Whole bus cycle; a read notes its expectation for the watcher
  task automatic av_cycle(input logic wr, input logic [1:0] idx, input logic [31:0] data,
                          input logic [31:0] exp, input logic [31:0] msk,
                          output logic [31:0] got);
    av_addr  <= idx;
    av_wdata <= data;
    av_wr    <= wr;
    av_rd    <= ~wr;
    if (!wr)
    begin
      rd_q.push_back(exp & msk);
      mk_q.push_back(msk);
    end
    do
      @(posedge core_clk);
    while (av_wait !== 1'b0);
    got = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge core_clk);
  endtask : av_cycle

  task automatic run_once(input logic [5:0] tgt, input logic [1:0] n1, input logic [1:0] n2,
                          input logic [2:0] ofs);
    logic [31:0] st;
    logic [31:0] cfg;
    logic [5:0]  rb;
    int          fin;
    int          n;
    rb  = (tgt > `BAND_MAX) ? `BAND_MAX : tgt;
    fin = int'(rb) + int'($signed(ofs));
    fin = (fin < 0) ? 0 : ((fin > 62) ? 62 : fin);
    cfg = (32'h1 << `EN_BIT) | (32'(`BW_NOM) << `BW_LSB) | (32'(n1) << `DIV_LSB)
        | (32'(n2) << `MUL_LSB) | (32'(`BIAS_NOM) << `BIAS_LSB)
        | (32'(`BAND_AUTO) << `BAND_LSB) | 32'(`DRV_NOM);
    lk_q.push_back(cfg);
    lk_q.push_back((cfg & ~32'h0000_00fc) | (32'(fin) << `BAND_LSB));
    target <= tgt;
    av_cycle(1'b1, `CTRL_IDX, {21'h0, ofs, 3'h0, n2, n1, 1'b1}, 32'h0, 32'h0, st);
    // Start already consumed, so a second one must be ignored
    av_cycle(1'b1, `CTRL_IDX, {21'h0, ofs, 3'h0, n2, n1, 1'b1}, 32'h0, 32'h0, st);
    do
      av_cycle(1'b0, `STAT_IDX, 32'h0, 32'h0, 32'h0, st);
    while (st[1] !== 1'b1 && st[2] !== 1'b1);
    n = 0;
    while (link_bus.lock !== 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      n++;
    end
    // Status shows the pin only after its two sync stages
    repeat (3) @(posedge core_clk);
    av_cycle(1'b0, `STAT_IDX, 32'h0, {10'h0, 6'(fin), 2'h0, rb, 8'h0a}, 32'hffff_ffff, st);
    av_cycle(1'b0, `CTRL_IDX, 32'h0, {21'h0, ofs, 3'h0, n2, n1, 1'b0}, 32'hffff_ffff, st);
    compare({31'h0, loop_on}, 32'h1, "loop on");
    compare({25'h0, vco_mult}, 32'h1 << (int'(n1) + int'(n2)), "vco ratio");
    compare({28'h0, smp_mult}, 32'h1 << n2, "sample ratio");
  endtask : run_once

  // Watcher for read answers
  always @(posedge core_clk)
  begin
    if (!sys_rst && av_rd && av_wait === 1'b0 && rd_q.size() > 0)
      compare(av_rdata & mk_q.pop_front(), rd_q.pop_front(), "bus read");
  end

  // Watcher for configuration words crossing the link
  always @(posedge core_clk)
  begin
    if (!sys_rst && link_bus.req && link_bus.we && !link_bus.ack && link_bus.addr == `CFG_ADDR)
      compare(link_bus.wdata, lk_q.pop_front(), "link word");
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    compare({25'h0, vco_mult, loop_on}, 32'h2, "bypass ratio");
    compare({28'h0, smp_mult}, 32'h1, "bypass sample ratio");
    av_cycle(1'b1, 2'h2, 32'hffff_ffff, 32'h0, 32'h0, r);
    av_cycle(1'b0, 2'h2, 32'h0, 32'h0, 32'hffff_ffff, r);
    av_cycle(1'b0, 2'h3, 32'h0, 32'h0, 32'hffff_ffff, r);
    av_cycle(1'b0, `STAT_IDX, 32'h0, 32'h0, 32'hffff_ffff, r);
    run_once(6'h00, 2'h3, 2'h0, 3'h4);
    run_once(6'h3f, 2'h0, 2'h3, 3'h3);
    repeat (3)
    begin
      r = $random(seed);
      run_once(r[5:0], r[7:6], r[9:8], r[12:10]);
    end
    test_done();
  end
endmodule : tb_pll_band_select_setup
`default_nettype wire

// File: src/pll_band_dev.sv
// Converter end: loop configuration register, band search and lock indication
`include "pll_consts.svh"
`default_nettype none
module pll_band_dev #(
  parameter int SETTLE = `SETTLE_EDGES
) (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  // Control port and pins
  pll_cfg_if.dev          LINK,
  // Best band under present conditions
  input  wire logic [5:0] TARGET_BAND,
  // Loop state
  output logic            LOOP_ON,
  output logic [6:0]      VCO_MULT,
  output logic [3:0]      SAMPLE_MULT
);

  logic               ref_s1_q;
  logic               ref_s2_q;
  logic               ref_s3_q;
  logic               ref_rise;
  logic [4:0]         bw_q;
  logic               en_q;
  logic [1:0]         div_q;
  logic [1:0]         mul_q;
  logic [2:0]         bias_q;
  pll_pkg::band_t     band_q;
  logic [1:0]         drv_q;
  logic               auto_q;
  pll_pkg::dev_state_e state_q;
  pll_pkg::band_t     cand_q;
  pll_pkg::band_t     tgt;
  logic [7:0]         cnt_q;
  logic               ack_q;
  logic               lock_q;
  logic [31:0]        rdata_q;
  logic               take;
  logic               wr_cfg;
  logic               settled;

  // Ratio code to ratio: 1, 2, 4, 8
  function automatic logic [3:0] ratio(input logic [1:0] code);
    ratio = 4'h1 << code;
  endfunction : ratio

  assign take     = LINK.req & ~ack_q;
  assign wr_cfg   = take & LINK.we & (LINK.addr == `CFG_ADDR);
  assign ref_rise = ref_s2_q & ~ref_s3_q;
  assign settled  = ref_rise & (cnt_q == 8'(SETTLE - 1));
  assign tgt      = (TARGET_BAND > `BAND_MAX) ? `BAND_MAX : TARGET_BAND;

  // Reference clock pin is foreign: two stages before use
  always_ff @(posedge CORE_CLK)
  begin
    ref_s1_q <= LINK.ref_clk;
    ref_s2_q <= ref_s1_q;
    ref_s3_q <= ref_s2_q;
  end

  // One-cycle answer to every request
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end
    else
    begin
      ack_q   <= take;
      rdata_q <= 32'h0;
      if (take && !LINK.we && LINK.addr == `CFG_ADDR)
        rdata_q <= {11'h0, bw_q, en_q, div_q, mul_q, bias_q, band_q, drv_q};
      else if (take && !LINK.we && LINK.addr == `STAT_ADDR)
        rdata_q[`LOCK_BIT] <= lock_q;
    end
  end

  // Configuration fields
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      bw_q   <= 5'h0;
      en_q   <= 1'b0;
      div_q  <= 2'h0;
      mul_q  <= 2'h0;
      bias_q <= 3'h0;
      band_q <= 6'h0;
      drv_q  <= 2'h0;
      auto_q <= 1'b0;
    end
    else if (wr_cfg)
    begin
      bw_q   <= LINK.wdata[`BW_MSB:`BW_LSB];
      en_q   <= LINK.wdata[`EN_BIT];
      div_q  <= LINK.wdata[`DIV_MSB:`DIV_LSB];
      mul_q  <= LINK.wdata[`MUL_MSB:`MUL_LSB];
      bias_q <= LINK.wdata[`BIAS_MSB:`BIAS_LSB];
      band_q <= LINK.wdata[`BAND_MSB:`BAND_LSB];
      drv_q  <= LINK.wdata[`DRV_MSB:`DRV_LSB];
      auto_q <= LINK.wdata[`BAND_MSB:`BAND_LSB] == `BAND_AUTO;
    end
    else if (state_q == pll_pkg::DEV_SEARCH && settled && auto_q && cand_q == tgt)
      // search result replaces the auto code
      band_q <= cand_q;
  end

  // Band search; stalls while the reference clock is absent
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      state_q <= pll_pkg::DEV_IDLE;
      cand_q  <= 6'h0;
      cnt_q   <= 8'h0;
    end
    else if (wr_cfg)
    begin
      state_q <= LINK.wdata[`EN_BIT] ? pll_pkg::DEV_SEARCH : pll_pkg::DEV_IDLE;
      cand_q  <= 6'h0;
      cnt_q   <= 8'h0;
    end
    else if (state_q == pll_pkg::DEV_SEARCH && ref_rise)
    begin
      cnt_q <= settled ? 8'h0 : cnt_q + 8'h1;
      if (settled)
      begin
        // step bands until the best one settles
        if (!auto_q || cand_q == tgt)
          state_q <= pll_pkg::DEV_LOCKED;
        else
          cand_q <= (cand_q == `BAND_MAX) ? 6'h0 : cand_q + 6'h1;
      end
    end
  end

  // Lock pin and multiplier outputs
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      lock_q      <= 1'b0;
      LOOP_ON     <= 1'b0;
      VCO_MULT    <= 7'h1;
      SAMPLE_MULT <= 4'h1;
    end
    else
    begin
      // lock pin follows the locked state
      lock_q      <= state_q == pll_pkg::DEV_LOCKED;
      LOOP_ON     <= en_q;
      // oscillator at both ratios, sample clock at output ratio
      VCO_MULT    <= en_q ? 7'(ratio(div_q)) * 7'(ratio(mul_q)) : 7'h1;
      // bypass passes the reference straight through
      SAMPLE_MULT <= en_q ? ratio(mul_q) : 4'h1;
    end
  end

  assign LINK.ack   = ack_q;
  assign LINK.rdata = rdata_q;
  assign LINK.lock  = lock_q;

endmodule : pll_band_dev
`default_nettype wire

// File: src/pll_band_host.sv
// Controller end: programs the loop, runs band selection, fixes the band
`include "pll_consts.svh"
`default_nettype none
module pll_band_host #(
  parameter int LOCK_TIMEOUT = `LOCK_WAIT_CYC,
  parameter int REF_HALF     = `REF_HALF_CYC
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  // Avalon-MM slave
  input  wire logic [1:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Control port and pins
  pll_cfg_if.host          LINK
);

  pll_pkg::host_state_e state_q;
  logic [1:0]           div_q;
  logic [1:0]           mul_q;
  logic [2:0]           ofs_q;
  logic                 start_q;
  logic                 done_q;
  logic                 fail_q;
  pll_pkg::band_t       rb_band_q;
  pll_pkg::band_t       fin_band_q;
  logic                 req_q;
  logic                 we_q;
  logic [4:0]           addr_q;
  logic [31:0]          wdata_q;
  logic                 ref_q;
  logic [7:0]           ref_cnt_q;
  logic                 lock_s1_q;
  logic                 lock_s2_q;
  logic [31:0]          tmo_q;
  logic                 bus_go;
  logic                 idle;

  // Configuration word with nominal tuning and the loop enabled
  function automatic logic [31:0] cfg_word(input pll_pkg::band_t band,
                                           input logic [1:0] dv,
                                           input logic [1:0] ml);
    logic [31:0] w;
    w = 32'h0;
    w[`BW_MSB:`BW_LSB]     = `BW_NOM;
    w[`DRV_MSB:`DRV_LSB]   = `DRV_NOM;
    w[`BIAS_MSB:`BIAS_LSB] = `BIAS_NOM;
    w[`EN_BIT]             = 1'b1;
    w[`DIV_MSB:`DIV_LSB]   = dv;
    w[`MUL_MSB:`MUL_LSB]   = ml;
    w[`BAND_MSB:`BAND_LSB] = band;
    cfg_word = w;
  endfunction : cfg_word

  // Readback plus signed offset, kept inside the fixed bands
  function automatic pll_pkg::band_t adjust(input pll_pkg::band_t rb,
                                            input logic [2:0] ofs);
    logic signed [7:0] sum;
    sum = $signed({2'b00, rb}) + $signed({{5{ofs[2]}}, ofs});
    if (sum < 0)
      adjust = 6'h0;
    else if (sum > $signed({2'b00, `BAND_MAX}))
      // never lands on the auto code
      adjust = `BAND_MAX;
    else
      adjust = sum[5:0];
  endfunction : adjust

  assign idle   = state_q == pll_pkg::HOST_IDLE;
  assign bus_go = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;

  // Free-running reference clock from a divider
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      ref_q     <= 1'b0;
      ref_cnt_q <= 8'h0;
    end
    // never gated, so the search never starves
    else if (ref_cnt_q == 8'(REF_HALF - 1))
    begin
      ref_q     <= ~ref_q;
      ref_cnt_q <= 8'h0;
    end
    else
      ref_cnt_q <= ref_cnt_q + 8'h1;
  end

  // Lock pin comes from the other party: two stages
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
    end
    else
    begin
      lock_s1_q <= LINK.lock;
      lock_s2_q <= lock_s1_q;
    end
  end

  // Avalon slave: answer one cycle after the request
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0;
    end
    else if (bus_go)
    begin
      AVS_WAITREQUEST <= 1'b0;
      AVS_READDATA    <= 32'h0;
      if (AVS_READ && AVS_ADDRESS == `CTRL_IDX)
        AVS_READDATA <= {21'h0, ofs_q, 3'h0, mul_q, div_q, 1'b0};
      else if (AVS_READ && AVS_ADDRESS == `STAT_IDX)
        AVS_READDATA <= {10'h0, fin_band_q, 2'h0, rb_band_q,
                         4'h0, lock_s2_q, fail_q, done_q, ~idle};
    end
    else
      AVS_WAITREQUEST <= 1'b1;
  end

  // Control register; writes land where waitrequest is low
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      div_q   <= 2'h0;
      mul_q   <= 2'h0;
      ofs_q   <= 3'h0;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `CTRL_IDX)
      begin
        if (AVS_BYTEENABLE[0])
        begin
          div_q   <= AVS_WRITEDATA[2:1];
          mul_q   <= AVS_WRITEDATA[4:3];
          // Start ignored while a run is in progress
          start_q <= AVS_WRITEDATA[0] & idle;
        end
        if (AVS_BYTEENABLE[1])
          ofs_q <= AVS_WRITEDATA[10:8];
      end
    end
  end

  // Sequencer and link requests
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      state_q    <= pll_pkg::HOST_IDLE;
      req_q      <= 1'b0;
      we_q       <= 1'b0;
      addr_q     <= 5'h0;
      wdata_q    <= 32'h0;
      done_q     <= 1'b0;
      fail_q     <= 1'b0;
      rb_band_q  <= 6'h0;
      fin_band_q <= 6'h0;
      tmo_q      <= 32'h0;
    end
    else
    begin
      unique case (state_q)
        pll_pkg::HOST_IDLE:
        begin
          if (start_q)
          begin
            done_q  <= 1'b0;
            fail_q  <= 1'b0;
            // ratios go out in the same word as the auto code
            req_q   <= 1'b1;
            we_q    <= 1'b1;
            addr_q  <= `CFG_ADDR;
            wdata_q <= cfg_word(`BAND_AUTO, div_q, mul_q);
            state_q <= pll_pkg::HOST_CFG;
          end
        end
        pll_pkg::HOST_CFG:
        begin
          if (LINK.ack)
          begin
            req_q   <= 1'b0;
            tmo_q   <= 32'h0;
            state_q <= pll_pkg::HOST_POLL;
          end
        end
        pll_pkg::HOST_POLL:
        begin
          tmo_q <= tmo_q + 32'h1;
          if (LINK.ack)
          begin
            req_q <= 1'b0;
            // status bit 3 counts as lock
            if (LINK.rdata[`LOCK_BIT])
              state_q <= pll_pkg::HOST_READ;
          end
          else if (!req_q)
          begin
            // pin trusted once the old lock has drained
            if (lock_s2_q && tmo_q >= 32'(`PIN_GUARD_CYC))
              state_q <= pll_pkg::HOST_READ;
            // give up after the lock interval
            else if (tmo_q >= 32'(LOCK_TIMEOUT - 1))
            begin
              fail_q  <= 1'b1;
              state_q <= pll_pkg::HOST_IDLE;
            end
            else
            begin
              req_q  <= 1'b1;
              we_q   <= 1'b0;
              addr_q <= `STAT_ADDR;
            end
          end
        end
        pll_pkg::HOST_READ:
        begin
          if (LINK.ack)
          begin
            req_q     <= 1'b0;
            // capture the band chosen by the search
            rb_band_q <= LINK.rdata[`BAND_MSB:`BAND_LSB];
            state_q   <= pll_pkg::HOST_FIX;
          end
          else if (!req_q)
          begin
            req_q  <= 1'b1;
            we_q   <= 1'b0;
            addr_q <= `CFG_ADDR;
          end
        end
        pll_pkg::HOST_FIX:
        begin
          if (LINK.ack)
          begin
            req_q   <= 1'b0;
            done_q  <= 1'b1;
            state_q <= pll_pkg::HOST_IDLE;
          end
          else if (!req_q)
          begin
            req_q      <= 1'b1;
            we_q       <= 1'b1;
            addr_q     <= `CFG_ADDR;
            // fix the band at readback plus offset
            fin_band_q <= adjust(rb_band_q, ofs_q);
            wdata_q    <= cfg_word(adjust(rb_band_q, ofs_q), div_q, mul_q);
          end
        end
        default:
          state_q <= pll_pkg::HOST_IDLE;
      endcase
    end
  end

  assign LINK.req     = req_q;
  assign LINK.we      = we_q;
  assign LINK.addr    = addr_q;
  assign LINK.wdata   = wdata_q;
  assign LINK.ref_clk = ref_q;

endmodule : pll_band_host
`default_nettype wire

// File: src/pll_cfg_if.sv
// Control port and pins between the loop controller and the converter
`default_nettype none
interface pll_cfg_if (
  input wire logic clk
);
  logic        req;
  logic        we;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  logic        ref_clk;
  logic        lock;

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    output ref_clk,
    input  rdata,
    input  ack,
    input  lock
  );

  modport dev (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    input  ref_clk,
    output rdata,
    output ack,
    output lock
  );
endinterface : pll_cfg_if
`default_nettype wire

// File: src/pll_consts.svh
// Constants shared by both ends of the loop configuration link
`ifndef PLL_CONSTS_SVH
`define PLL_CONSTS_SVH

// Device register addresses
`define CFG_ADDR      5'h04
`define STAT_ADDR     5'h09

// Configuration word field positions and the status word lock bit
`define BW_MSB        20
`define BW_LSB        16
`define EN_BIT        15
`define DIV_MSB       14
`define DIV_LSB       13
`define MUL_MSB       12
`define MUL_LSB       11
`define BIAS_MSB      10
`define BIAS_LSB      8
`define BAND_MSB      7
`define BAND_LSB      2
`define DRV_MSB       1
`define DRV_LSB       0
`define LOCK_BIT      3

// Field values
`define BAND_AUTO     6'h3f
`define BAND_MAX      6'h3e
`define BW_NOM        5'h0f
`define DRV_NOM       2'h3
`define BIAS_NOM      3'h3

// Controller register word indices
`define CTRL_IDX      2'h0
`define STAT_IDX      2'h1

// Timing
`define CORE_HZ       20000000
`define LOCK_WAIT_US  5000
`define LOCK_WAIT_CYC (`LOCK_WAIT_US * (`CORE_HZ / 1000000))
`define REF_HALF_CYC  2
`define SETTLE_EDGES  16
`define PIN_GUARD_CYC 4

`endif

// File: src/pll_pkg.sv
// Types shared by both ends of the loop configuration link
`default_nettype none
package pll_pkg;

  typedef logic [5:0] band_t;

  typedef enum logic [1:0] {
    DEV_IDLE,
    DEV_SEARCH,
    DEV_LOCKED
  } dev_state_e;

  typedef enum logic [2:0] {
    HOST_IDLE,
    HOST_CFG,
    HOST_POLL,
    HOST_READ,
    HOST_FIX
  } host_state_e;

endpackage : pll_pkg
`default_nettype wire
